//--- eba_params.svh
// Purpose: Constants for the extender bus arbiter and timeout block.
// Assumes: 10 MHz core clock, 100 ns period.
// Notes: Times are in their own units; cycle counts derive from them.
`ifndef EBA_PARAMS_SVH
`define EBA_PARAMS_SVH
`define EBA_CLK_NS 100
`define EBA_US_NS 1000
`define EBA_US_CYCLES ((`EBA_US_NS + `EBA_CLK_NS - 1) / `EBA_CLK_NS)
`define EBA_MS_US 1000
`define EBA_CABLE_T1 100
`define EBA_CABLE_T2 200
`define EBA_CABLE_T3 400
`define EBA_BP_T1_US 100
`define EBA_BP_T2_US 200
`define EBA_BP_T3_US 400
`define EBA_BP_LEVEL_RESET 2'h3
`endif

//--- eba_pkg.sv
// Purpose: Types shared by the extender bus arbiter files.
// Assumes: Nothing beyond the constants header.
// Notes: Selection codes travel as enums; cable lines as a struct.
package eba_pkg;
  typedef enum logic [1:0] {EBA_TO_100, EBA_TO_200, EBA_TO_400, EBA_TO_OFF} eba_tsel_e;
  typedef enum logic [1:0] {EBA_CHAIN_ONLY, EBA_CHAIN_HOLDER, EBA_CHAIN_LEFT, EBA_CHAIN_RIGHT}
    eba_chain_e;
  typedef struct packed {
    logic ds;
    logic dtack;
    logic berr;
  } eba_cyc_s;
endpackage : eba_pkg

//--- eba_tick.sv
// Purpose: Scale tick generator: one pulse per microsecond or millisecond.
// Assumes: Synchronous active-low reset.
// Notes: The millisecond tick is built from microsecond ticks.
`timescale 1ns/1ps
`include "eba_params.svh"
module eba_tick
  import eba_pkg::*;
#(
  parameter int US_CYC = `EBA_US_CYCLES,
  parameter int MS_US = `EBA_MS_US
) (
  input wire logic core_clk,
  input wire logic resetn,
  output logic us_tick,
  output logic ms_tick
);
  logic [15:0] us_cnt_q;
  logic [15:0] ms_cnt_q;
  wire us_wrap = (us_cnt_q == 16'(US_CYC - 1));
  wire ms_wrap = (ms_cnt_q == 16'(MS_US - 1)) & us_wrap;
  // ----------------------------------------
  // Free-running prescalers.
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      us_cnt_q <= 16'h0000;
      ms_cnt_q <= 16'h0000;
    end else begin
      us_cnt_q <= us_wrap ? 16'h0000 : us_cnt_q + 16'h0001;
      if (us_wrap) ms_cnt_q <= (ms_cnt_q == 16'(MS_US - 1)) ? 16'h0000 : ms_cnt_q + 16'h0001;
    end
  end
  assign us_tick = us_wrap;
  assign ms_tick = ms_wrap;
endmodule : eba_tick

//--- eba_timer.sv
// Purpose: One strobe-to-acknowledge watchdog raising bus error on expiry.
// Assumes: Ticks are single-cycle pulses from the prescaler.
// Notes: Used for both the cable and the backplane timeout units.
`timescale 1ns/1ps
module eba_timer
  import eba_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic [8:0] limit,
  input eba_cyc_s cyc,
  output logic berr_out,
  output logic busy
);
  typedef enum {EBA_T_IDLE, EBA_T_RUN, EBA_T_ERR} eba_tstate_e;
  eba_tstate_e st_q;
  logic [8:0] cnt_q;
  logic berr_q;
  wire ends = cyc.dtack | cyc.berr;
  wire expire = tick & (cnt_q == limit - 9'h001);
  // ----------------------------------------
  // Watchdog state machine; returns idle on a cycle end while running, and on strobe release or lost enable.
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= EBA_T_IDLE;
      cnt_q <= 9'h000;
      berr_q <= 1'b0;
    end else begin
      case (st_q)
        EBA_T_IDLE: begin
          cnt_q <= 9'h000;
          berr_q <= 1'b0;
          if (enable && cyc.ds && !ends) st_q <= EBA_T_RUN;
        end
        EBA_T_RUN: begin
          // A strobe dropped without an answer abandons the cycle, so no late error fires.
          if (!enable || ends || !cyc.ds) begin
            st_q <= EBA_T_IDLE;
          end else if (expire) begin
            st_q <= EBA_T_ERR;
            berr_q <= 1'b1;
          end else if (tick) begin
            cnt_q <= cnt_q + 9'h001;
          end
        end
        default: begin
          // Hold error until the strobe is released so the master sees it.
          // Losing the enable also clears it at the next edge, so a disabled unit drives error for at most one cycle.
          if (!cyc.ds || !enable) begin
            st_q <= EBA_T_IDLE;
            berr_q <= 1'b0;
          end
        end
      endcase
    end
  end
  assign berr_out = berr_q;
  assign busy = (st_q != EBA_T_IDLE);
endmodule : eba_timer

//--- eba_top.sv
// Purpose: Cable-bus controller arbitration and timeout plus backplane timeout.
// Assumes: All inputs synchronous to core_clk; 10 MHz clock.
// Notes: Straps are plain inputs; the long scale bit is a software level.
`timescale 1ns/1ps
`include "eba_params.svh"
module eba_top
  import eba_pkg::*;
#(
  parameter int NREQ = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sys_ctrl_en,
  input wire logic fair_en,
  input wire logic interlock_en,
  input wire logic long_timeout_scale_bit,
  input eba_tsel_e controller_timeout_level_select,
  input eba_tsel_e bp_timeout_level_select,
  input eba_chain_e timeout_chain_position_select,
  input eba_cyc_s cable_cyc,
  input eba_cyc_s bp_cyc,
  input wire logic [NREQ-1:0] cable_req_in,
  output logic [NREQ-1:0] cable_grant,
  input wire logic cable_iack_in,
  output logic cable_iack_out,
  output logic cable_berr_o,
  output logic cable_berr_oe,
  input wire logic local_need,
  input wire logic cable_busreq_seen,
  output logic local_req,
  input wire logic inbound_want,
  input wire logic local_outward,
  output logic bp_berr_o,
  output logic bp_berr_oe,
  output logic [1:0] bp_req_level,
  input wire logic lb_suppress_left,
  input wire logic lb_suppress_right,
  output logic lb_suppress_out,
  input wire logic ilk_busy_in,
  output logic ilk_busy_out
);
  // ----------------------------------------
  // Timebase and selection decode.
  // ----------------------------------------
  logic us_tick;
  logic ms_tick;
  eba_tick u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );
  // Cable limit chosen from the strap; scale follows the software bit.
  wire [8:0] cable_limit = (controller_timeout_level_select == EBA_TO_100) ? 9'(`EBA_CABLE_T1) :
                           (controller_timeout_level_select == EBA_TO_200) ? 9'(`EBA_CABLE_T2) :
                           9'(`EBA_CABLE_T3);
  wire cable_tick = long_timeout_scale_bit ? ms_tick : us_tick;
  wire [8:0] bp_limit = (bp_timeout_level_select == EBA_TO_100) ? 9'(`EBA_BP_T1_US) :
                        (bp_timeout_level_select == EBA_TO_200) ? 9'(`EBA_BP_T2_US) :
                        9'(`EBA_BP_T3_US);
  // ----------------------------------------
  // Cable-bus controller timeout.
  // ----------------------------------------
  logic cable_to_berr;
  logic cable_to_busy;
  eba_timer u_cable_to (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(sys_ctrl_en),
    .tick(cable_tick),
    .limit(cable_limit),
    .cyc(cable_cyc),
    .berr_out(cable_to_berr),
    .busy(cable_to_busy)
  );
  // ----------------------------------------
  // Backplane timeout; off while any outward cable transfer runs.
  // ----------------------------------------
  wire holder = (timeout_chain_position_select != EBA_CHAIN_LEFT) &&
                (timeout_chain_position_select != EBA_CHAIN_RIGHT);
  wire suppress = local_outward | lb_suppress_left | lb_suppress_right;
  wire bp_en = holder && (bp_timeout_level_select != EBA_TO_OFF) && !suppress;
  logic bp_to_berr;
  eba_timer u_bp_to (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(bp_en),
    .tick(us_tick),
    .limit(bp_limit),
    .cyc(bp_cyc),
    .berr_out(bp_to_berr),
    .busy()
  );
  // Non-holders pass the outward indication along the local bus.
  assign lb_suppress_out = !holder & (local_outward | lb_suppress_left | lb_suppress_right);
  // ----------------------------------------
  // Cable arbiter: fixed priority, index 0 nearest the controller.
  // ----------------------------------------
  logic [NREQ-1:0] grant_q;
  logic [NREQ-1:0] grant_d;
  always_comb begin
    grant_d = '0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (cable_req_in[i]) grant_d = NREQ'(1) << i;
    end
  end
  // Hold a grant until its request drops, so a busy owner is cut off only when sys_ctrl_en falls.
  wire owner_drop = ((grant_q & cable_req_in) == '0);
  always_ff @(posedge core_clk) begin
    if (!resetn) grant_q <= '0;
    else if (!sys_ctrl_en) grant_q <= '0;
    else if (owner_drop) grant_q <= grant_d;
  end
  assign cable_grant = grant_q;
  // Acknowledge chain is driven only by the controller.
  assign cable_iack_out = sys_ctrl_en & cable_iack_in;
  // ----------------------------------------
  // Local requester: fairness and interlock.
  // ----------------------------------------
  logic fair_hold_q;
  logic req_q;
  // Interlocked: a new request waits while the system-wide busy line is up.
  wire ilk_wait = interlock_en & ilk_busy_in;
  // Once requesting, the fair hold is released so the request stays up.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fair_hold_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      fair_hold_q <= fair_en & cable_busreq_seen & !req_q;
      if (!local_need) req_q <= 1'b0;
      else if (ilk_wait) req_q <= req_q;
      else if (!fair_en) req_q <= 1'b1;
      else if (!cable_busreq_seen && !fair_hold_q) req_q <= 1'b1;
    end
  end
  // Interlocked: wait for the system-wide busy line to clear.
  wire ilk_block = interlock_en & ilk_busy_in & !req_q;
  assign local_req = req_q & !ilk_block;
  assign ilk_busy_out = interlock_en & (local_req | inbound_want);
  assign bp_req_level = `EBA_BP_LEVEL_RESET;
  // ----------------------------------------
  // Deadlock resolution in normal mode.
  // ----------------------------------------
  wire deadlock = !interlock_en & inbound_want & local_outward;
  logic dl_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) dl_q <= 1'b0;
    else dl_q <= deadlock;
  end
  assign cable_berr_o = cable_to_berr;
  assign cable_berr_oe = cable_to_berr;
  assign bp_berr_o = bp_to_berr | dl_q;
  assign bp_berr_oe = bp_to_berr | dl_q;
  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  a_no_to_nonctrl: assert property (@(posedge core_clk) disable iff (!resetn)
    !sys_ctrl_en |-> ##1 !cable_berr_oe) else $error("cable error while not controller");
  a_ack_stops: assert property (@(posedge core_clk) disable iff (!resetn)
    (cable_to_busy && !cable_berr_o && (cable_cyc.dtack || cable_cyc.berr)) |=> !cable_to_busy)
    else $error("timeout did not stop on ack");
  a_err_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    (cable_berr_o && !cable_cyc.ds) |=> (!cable_berr_o && !cable_to_busy))
    else $error("timeout not idle after error");
  a_err_cause: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(cable_berr_o) |-> $past(cable_tick) && $past(sys_ctrl_en))
    else $error("cable error without tick");
  a_fair_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    (fair_en && !req_q && cable_busreq_seen) |=> !req_q) else $error("fair request early");
  a_unfair_req: assert property (@(posedge core_clk) disable iff (!resetn)
    (!fair_en && local_need && !ilk_wait) |=> req_q) else $error("unfair request missing");
  a_ilk_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    (ilk_wait && !req_q) |=> !local_req) else $error("interlocked request early");
  a_prio_grant: assert property (@(posedge core_clk) disable iff (!resetn)
    (sys_ctrl_en && grant_q == '0 && cable_req_in[0]) |=> cable_grant[0])
    else $error("nearest requester lost");
  a_deadlock_err: assert property (@(posedge core_clk) disable iff (!resetn)
    deadlock |=> bp_berr_oe) else $error("deadlock not ended");
  a_suppress_bp: assert property (@(posedge core_clk) disable iff (!resetn)
    (suppress && !dl_q && !bp_to_berr) |=> !bp_to_berr) else $error("bp timeout not held");
  a_ilk_level: assert property (@(posedge core_clk) disable iff (!resetn)
    bp_req_level == 2'h3) else $error("wrong request level");
  c_cable_to: cover property (@(posedge core_clk) disable iff (!resetn) $rose(cable_berr_o));
  c_deadlock: cover property (@(posedge core_clk) disable iff (!resetn) deadlock);
  c_fair: cover property (@(posedge core_clk) disable iff (!resetn) fair_en && $rose(req_q));
endmodule : eba_top

//--- eba_far_model.sv
// Purpose: Far-side partner that strobes a cycle and may acknowledge it.
// Assumes: The bench raises start at a falling edge and holds it.
// Notes: An ack_after of zero models a slave that never answers.
`timescale 1ns/1ps
module eba_far_model
  import eba_pkg::*;
(
  input wire logic core_clk,
  input wire logic start,
  input wire logic [15:0] ack_after,
  output eba_cyc_s cyc
);
  // ----------------------------------------
  // Strobe and acknowledge
  // ----------------------------------------
  logic [15:0] cnt_q;
  initial begin
    cnt_q = 16'h0000;
    cyc = '0;
  end
  // Lines change only at falling edges so the block samples settled levels.
  always @(negedge core_clk) begin
    cnt_q <= start ? cnt_q + 16'h0001 : 16'h0000;
    cyc.ds <= start;
    cyc.dtack <= start && (ack_after != 16'h0000) && (cnt_q >= ack_after);
    cyc.berr <= 1'b0;
  end
endmodule : eba_far_model

//--- eba_top_tb.sv
// Purpose: Self-checking bench for the extender arbiter and timeouts.
// Assumes: 100 ns clock; microsecond tick every ten cycles.
// Notes: The millisecond scale is only shown not to fire early.
`timescale 1ns/1ps
module eba_top_tb;
  import eba_pkg::*;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic sc = 1'b0, fair = 1'b0, ilk = 1'b0, lng = 1'b0, need = 1'b0, seen = 1'b0;
  logic iack = 1'b0, inb = 1'b0, outw = 1'b0, supl = 1'b0, go_c = 1'b0, go_b = 1'b0;
  logic ibz = 1'b0, supr = 1'b0;
  logic [3:0] req = 4'h0;
  logic [15:0] ack = 16'h0000;
  eba_chain_e chain = EBA_CHAIN_HOLDER;
  eba_cyc_s ccyc, bcyc;
  logic [3:0] grant;
  logic iack_o, cberr, cberr_oe, lreq, bberr, bberr_oe, sup_o, ibo;
  logic [1:0] lvl;
  int mismatches = 0;
  int cmp_count = 0;
  always #50 core_clk = ~core_clk;
  eba_far_model cab (.core_clk(core_clk), .start(go_c), .ack_after(ack), .cyc(ccyc));
  eba_far_model bpm (.core_clk(core_clk), .start(go_b), .ack_after(ack), .cyc(bcyc));
  eba_top #(.NREQ(4)) dut (.core_clk(core_clk), .resetn(resetn), .sys_ctrl_en(sc),
    .fair_en(fair), .interlock_en(ilk), .long_timeout_scale_bit(lng),
    .controller_timeout_level_select(EBA_TO_100), .bp_timeout_level_select(EBA_TO_100),
    .timeout_chain_position_select(chain), .cable_cyc(ccyc), .bp_cyc(bcyc),
    .cable_req_in(req), .cable_grant(grant), .cable_iack_in(iack),
    .cable_iack_out(iack_o), .cable_berr_o(cberr), .cable_berr_oe(cberr_oe),
    .local_need(need), .cable_busreq_seen(seen), .local_req(lreq),
    .inbound_want(inb), .local_outward(outw), .bp_berr_o(bberr), .bp_berr_oe(bberr_oe),
    .bp_req_level(lvl), .lb_suppress_left(supl), .lb_suppress_right(supr),
    .lb_suppress_out(sup_o), .ilk_busy_in(ibz), .ilk_busy_out(ibo));
  task automatic check(input string what, input logic [3:0] seen_v, input logic [3:0] exp);
    cmp_count++;
    if (seen_v !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : check
  task automatic cyc_wait(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc_wait
  // Holds one strobe for 1030 cycles; 100 us is 1000 cycles give or take a tick.
  task automatic run_ds(input bit bp, input int dly, input logic exp);
    ack = 16'(dly);
    if (bp) go_b = 1'b1; else go_c = 1'b1;
    cyc_wait(980);
    check("berr early", bp ? bberr : cberr, 4'h0);
    cyc_wait(50);
    check("berr expiry", bp ? bberr : cberr, {3'b000, exp});
    if (!bp) check("berr enable", cberr_oe, {3'b000, exp});
    if (bp) check("bp berr enable", bberr_oe, {3'b000, exp});
    go_b = 1'b0;
    go_c = 1'b0;
    cyc_wait(3);
    check("berr after cycle", bp ? bberr : cberr, 4'h0);
  endtask : run_ds
  task automatic t_reset;
    check("level", lvl, 4'h3);
    check("grant idle", grant, 4'h0);
    iack = 1'b1;
    cyc_wait(1);
    check("iack pass", iack_o, 4'h0);
    check("bp berr idle", bberr, 4'h0);
    check("busy idle", ibo, 4'h0);
    check("suppress idle", sup_o, 4'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cable;
    sc = 1'b1;
    cyc_wait(1);
    check("iack chain", iack_o, 4'h1);
    run_ds(1'b0, 0, 1'b1);
    run_ds(1'b0, 500, 1'b0);
    lng = 1'b1;
    run_ds(1'b0, 0, 1'b0);
    lng = 1'b0;
    run_ds(1'b0, 0, 1'b1);
    sc = 1'b0;
    run_ds(1'b0, 0, 1'b0);
    $display("test cable timeout done");
  endtask : t_cable
  task automatic t_arb;
    sc = 1'b1;
    req = 4'b1010;
    cyc_wait(3);
    check("grant near", grant, 4'b0010);
    req = 4'h0;
    cyc_wait(2);
    req = 4'b1001;
    cyc_wait(2);
    check("grant first", grant, 4'b0001);
    req = 4'h0;
    need = 1'b1;
    seen = 1'b1;
    cyc_wait(3);
    check("unfair req", lreq, 4'h1);
    need = 1'b0;
    fair = 1'b1;
    cyc_wait(2);
    need = 1'b1;
    cyc_wait(4);
    check("fair hold", lreq, 4'h0);
    seen = 1'b0;
    cyc_wait(4);
    check("fair req", lreq, 4'h1);
    {need, fair, sc} = 3'b000;
    $display("test arbitration done");
  endtask : t_arb
  task automatic t_bp;
    inb = 1'b1;
    outw = 1'b1;
    cyc_wait(3);
    check("deadlock berr", bberr, 4'h1);
    ilk = 1'b1;
    cyc_wait(3);
    check("interlock berr", bberr, 4'h0);
    check("busy out", ibo, 4'h1);
    ibz = 1'b1;
    need = 1'b1;
    cyc_wait(3);
    check("ilk wait", lreq, 4'h0);
    ibz = 1'b0;
    cyc_wait(3);
    check("ilk req", lreq, 4'h1);
    {inb, outw, ilk, need} = 4'b0000;
    cyc_wait(3);
    supl = 1'b1;
    run_ds(1'b1, 0, 1'b0);
    supl = 1'b0;
    run_ds(1'b1, 0, 1'b1);
    chain = EBA_CHAIN_LEFT;
    outw = 1'b1;
    cyc_wait(2);
    check("suppress out", sup_o, 4'h1);
    outw = 1'b0;
    supr = 1'b1;
    cyc_wait(2);
    check("suppress pass", sup_o, 4'h1);
    $display("test backplane done");
  endtask : t_bp
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // The tests need about 7,300 cycles; the watchdog allows 20,000.
  initial begin
    #2000000;
    mismatches++;
    stop_test();
  end
  initial begin
    cyc_wait(20);
    resetn = 1'b1;
    cyc_wait(1);
    t_reset();
    t_cable();
    t_arb();
    t_bp();
    stop_test();
  end
endmodule : eba_top_tb
